/* logic/gpi_consts.svh */
// Offsets, field positions, reset values and widths of the pin input block.
// Assumes an 8-bit register port with byte-wide registers.
`ifndef GPI_CONSTS_SVH
`define GPI_CONSTS_SVH

// Widths
`define GPI_NPIN 21
`define GPI_AW 8
`define GPI_DW 8

// Register offsets
`define GPI_OFS_P0_FLAG 8'h89
`define GPI_OFS_P1_FLAG 8'h8A
`define GPI_OFS_P2_FLAG 8'h8B
`define GPI_OFS_CTL 8'h8C
`define GPI_OFS_P1_IEN 8'h8D
`define GPI_OFS_P0_MODE 8'h8F
`define GPI_OFS_P1_MODE 8'hF6
`define GPI_OFS_P2_MODE 8'hF7

// Control register fields
`define GPI_CTL_BOOST 6
`define GPI_CTL_P2_IEN 5
`define GPI_CTL_P0_IENH 4
`define GPI_CTL_P0_IENL 3
`define GPI_CTL_FALL_MSB 2

// Port 2 mode register fields
`define GPI_PDN_LSB 5
`define GPI_P2_MODE_MSB 4

// Port 1 mode field starts above two unused bits
`define GPI_P1_MODE_LSB 2
`define GPI_P1_FIXED_TRI 2'h3

// Reset value of every register
`define GPI_RST_BYTE 8'h00

// Input filter warm-up count
`define GPI_WARM 2'h3

`endif

/* logic/gpi_link_if.sv */
// Carries pin events to the core and pad settings to the pad driver.
// Assumes one clock shared by all three modules.
`timescale 1ns/1ps
`include "gpi_consts.svh"

interface gpi_link_if;
	logic [`GPI_NPIN-1:0] rise;
	logic [`GPI_NPIN-1:0] fall;
	logic [`GPI_NPIN-1:0] tri_mode;
	logic [2:0] pull_dn;
	modport sync_mp (output rise, output fall);
	modport core_mp (input rise, input fall, output tri_mode, output pull_dn);
	modport pads_mp (input tri_mode, input pull_dn);
endinterface : gpi_link_if

/* logic/gpi_pads.sv */
// Pull resistor enables per pin, registered toward the pad ring.
// Assumes the core holds a tristate bit per pin and one direction per port.
`timescale 1ns/1ps
`include "gpi_consts.svh"

module gpi_pads (
	// Clock and control
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Settings
	gpi_link_if.pads_mp lnk,
	// Pads
	output logic [`GPI_NPIN-1:0] pull_up_en,
	output logic [`GPI_NPIN-1:0] pull_down_en
);
	gpi_pkg::gpi_pads_st_t q;
	gpi_pkg::gpi_pads_st_t d;
	logic [`GPI_NPIN-1:0] dn_sel;

	// Port direction bit fanned out to its pins
	for (genvar i = 0; i < `GPI_NPIN; i++) begin : g_pin
		assign dn_sel[i] = lnk.pull_dn[(i < 8) ? 0 : ((i < 16) ? 1 : 2)];
	end

	always_comb begin
		d = q;
		d.pu = ~lnk.tri_mode & ~dn_sel; // [RL3] [RL4] [RL5]
		d.pd = ~lnk.tri_mode & dn_sel; // [RL1] [RL2] [RL13]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign pull_up_en = q.pu;
	assign pull_down_en = q.pd;

	// Not from the last reset edge: pulls are still clear after it
	pull_follow_a: assert property ( // [RL13]
		@(posedge sys_clk) disable iff (sys_rst)
		ce && !sys_rst |=> (q.pu | q.pd) == ~$past(lnk.tri_mode))
		else $error("pull enable does not follow input mode");
	pull_dir_a: assert property ( // [RL3]
		@(posedge sys_clk) disable iff (sys_rst)
		ce && !sys_rst |=> (q.pd == ($past(dn_sel) & (q.pu | q.pd))))
		else $error("pull direction wrong");
	no_fight_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(q.pu & q.pd) == '0)
		else $error("pull-up and pull-down both on");

endmodule : gpi_pads

/* logic/gpi_pkg.sv */
// Types of the pin input block: the state record of each module.
// Assumes gpi_consts.svh is on the include path.
`include "gpi_consts.svh"

package gpi_pkg;

	typedef struct packed {
		logic [`GPI_NPIN-1:0] s1;
		logic [`GPI_NPIN-1:0] s2;
		logic [`GPI_NPIN-1:0] s3;
		logic [`GPI_NPIN-1:0] lvl;
		logic [`GPI_NPIN-1:0] rise;
		logic [`GPI_NPIN-1:0] fall;
		logic [1:0] cnt;
	} gpi_sync_st_t;

	typedef struct packed {
		logic [`GPI_NPIN-1:0] pu;
		logic [`GPI_NPIN-1:0] pd;
	} gpi_pads_st_t;

	typedef struct packed {
		logic [7:0] p0_mode;
		logic [5:0] p1_mode;
		logic [4:0] p2_mode;
		logic [2:0] pull_dn;
		logic boost;
		logic p2_ien;
		logic p0_ienh;
		logic p0_ienl;
		logic [2:0] fall_sel;
		logic [7:0] p1_ien;
		logic [7:0] p0_flag;
		logic [7:0] p1_flag;
		logic [4:0] p2_flag;
		logic [7:0] rdata;
		logic [2:0] irq;
	} gpi_core_st_t;

endpackage : gpi_pkg

/* logic/gpi_sync.sv */
// Pin synchroniser and edge finder for all 21 inputs.
// Assumes asynchronous pins; events are one-cycle pulses.
`timescale 1ns/1ps
`include "gpi_consts.svh"

module gpi_sync (
	// Clock and control
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Pins
	input wire logic [`GPI_NPIN-1:0] pin_in,
	// Events
	gpi_link_if.sync_mp lnk
);
	gpi_pkg::gpi_sync_st_t q;
	gpi_pkg::gpi_sync_st_t d;
	logic [`GPI_NPIN-1:0] agree;
	logic warm;

	assign agree = ~(q.s2 ^ q.s3);
	assign warm = (q.cnt == `GPI_WARM);

	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.cnt = warm ? q.cnt : q.cnt + 2'h1;
		// Before warm-up the level is taken without events
		d.lvl = warm ? ((q.lvl & ~agree) | (q.s3 & agree)) : q.s2;
		d.rise = warm ? (agree & q.s3 & ~q.lvl) : '0;
		d.fall = warm ? (agree & ~q.s3 & q.lvl) : '0;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign lnk.rise = q.rise;
	assign lnk.fall = q.fall;

	rise_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && warm && q.s2[0] && q.s3[0] && !q.lvl[0] |=> q.rise[0] && q.lvl[0])
		else $error("rise event missing after stable high");
	glitch_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && (q.s2[0] != q.s3[0]) |=> !q.rise[0] && !q.fall[0])
		else $error("event taken while stages disagree");

endmodule : gpi_sync

/* logic/gpi_top.sv */
// Input mode, pull control and pin request flags for three I/O ports.
// Assumes a byte register port with one-cycle strobes and async pins.
//
// Functional notes
// RL1 - Port 1 pins 7..2 are pulled when their mode bit is 0, tristate at 1.
// RL2 - Port 2 pins 4..0 are pulled when their mode bit is 0, tristate at 1.
// RL3 - Port 2 pulled inputs pull up at 0 and down at 1, reset to up.
// RL4 - Port 1 pulled inputs pull up at 0 and down at 1, reset to up.
// RL5 - Port 0 pulled inputs pull up at 0 and down at 1, reset to up.
// RL6 - A pending request on a port 0 pin sets its flag; flags reset to 0.
// RL7 - A pending request on a port 1 pin sets its flag; flags reset to 0.
// RL8 - Port 2 has five flags and the top three bits read as 0.
// RL9 - The drive bit picks minimum drive at 0 and maximum drive at 1.
// RL10 - One bit enables port 2 requests; it resets to disabled.
// RL11 - One bit enables requests of port 0 pins 7..4.
// RL12 - One bit enables requests of port 0 pins 3..0.
// RL13 - Port 0 pins 7..0 are pulled when their mode bit is 0, tristate at 1.
// RL14 - Per port, edge select 0 means rising and 1 means falling edge.
// RL15 - Each port 1 pin has its own request enable, reset to disabled.
// RL16 - Writing 0 to a flag bit clears it; writing 1 leaves it.
// RL17 - A port requests while any enabled flag of that port is set.
`timescale 1ns/1ps
`include "gpi_consts.svh"

module gpi_top (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Register port
	input wire logic [`GPI_AW-1:0] addr,
	input wire logic [`GPI_DW-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [`GPI_DW-1:0] rdata,
	// Pins
	input wire logic [7:0] p0_pin_in,
	input wire logic [7:0] p1_pin_in,
	input wire logic [4:0] p2_pin_in,
	// Pad control
	output logic [`GPI_NPIN-1:0] pull_up_en,
	output logic [`GPI_NPIN-1:0] pull_down_en,
	output logic drive_boost,
	// Port requests
	output logic p0_irq,
	output logic p1_irq,
	output logic p2_irq
);
	gpi_pkg::gpi_core_st_t q;
	gpi_pkg::gpi_core_st_t d;
	gpi_link_if lnk ();

	logic [`GPI_NPIN-1:0] fall_v;
	logic [`GPI_NPIN-1:0] set_v;
	logic [7:0] clr0;
	logic [7:0] clr1;
	logic [4:0] clr2;
	logic wr_p0f;
	logic wr_p1f;
	logic wr_p2f;

	// Pin path

	gpi_sync u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.pin_in({p2_pin_in, p1_pin_in, p0_pin_in}),
		.lnk(lnk)
	);

	gpi_pads u_pads (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.lnk(lnk),
		.pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en)
	);

	// Pins 1..0 of port 1 have no pull and stay tristate
	assign lnk.tri_mode = {q.p2_mode, q.p1_mode, `GPI_P1_FIXED_TRI,
		q.p0_mode}; // [RL1] [RL2] [RL13]
	assign lnk.pull_dn = q.pull_dn; // [RL3] [RL4] [RL5]

	// Request condition

	assign fall_v = {{5{q.fall_sel[2]}}, {8{q.fall_sel[1]}},
		{8{q.fall_sel[0]}}};
	assign set_v = (lnk.rise & ~fall_v) | (lnk.fall & fall_v); // [RL14]

	// Flag clears

	assign wr_p0f = wr_stb && (addr == `GPI_OFS_P0_FLAG);
	assign wr_p1f = wr_stb && (addr == `GPI_OFS_P1_FLAG);
	assign wr_p2f = wr_stb && (addr == `GPI_OFS_P2_FLAG);
	assign clr0 = wr_p0f ? ~wdata : 8'h00; // [RL16]
	assign clr1 = wr_p1f ? ~wdata : 8'h00; // [RL16]
	assign clr2 = wr_p2f ? ~wdata[4:0] : 5'h00; // [RL16]

	always_comb begin
		d = q;
		d.rdata = `GPI_RST_BYTE;

		// Configuration writes
		if (wr_stb) begin
			case (addr)
				`GPI_OFS_P0_MODE: begin
					d.p0_mode = wdata; // [RL13]
				end
				`GPI_OFS_P1_MODE: begin
					d.p1_mode = wdata[7:`GPI_P1_MODE_LSB]; // [RL1]
				end
				`GPI_OFS_P2_MODE: begin
					d.pull_dn = wdata[7:`GPI_PDN_LSB]; // [RL3] [RL4] [RL5]
					d.p2_mode = wdata[`GPI_P2_MODE_MSB:0]; // [RL2]
				end
				`GPI_OFS_CTL: begin
					d.boost = wdata[`GPI_CTL_BOOST]; // [RL9]
					d.p2_ien = wdata[`GPI_CTL_P2_IEN]; // [RL10]
					d.p0_ienh = wdata[`GPI_CTL_P0_IENH]; // [RL11]
					d.p0_ienl = wdata[`GPI_CTL_P0_IENL]; // [RL12]
					d.fall_sel = wdata[`GPI_CTL_FALL_MSB:0]; // [RL14]
				end
				`GPI_OFS_P1_IEN: begin
					d.p1_ien = wdata; // [RL15]
				end
				default: begin
					d.rdata = `GPI_RST_BYTE;
				end
			endcase
		end

		// A new event wins over a clear in the same cycle
		d.p0_flag = (q.p0_flag & ~clr0) | set_v[7:0]; // [RL6] [RL16]
		d.p1_flag = (q.p1_flag & ~clr1) | set_v[15:8]; // [RL7] [RL16]
		d.p2_flag = (q.p2_flag & ~clr2) | set_v[20:16]; // [RL8] [RL16]

		// Port requests from enabled flags
		d.irq[0] = (q.p0_ienh && (q.p0_flag[7:4] != 4'h0)) ||
			(q.p0_ienl && (q.p0_flag[3:0] != 4'h0)); // [RL11] [RL12] [RL17]
		d.irq[1] = ((q.p1_flag & q.p1_ien) != 8'h00); // [RL15] [RL17]
		d.irq[2] = q.p2_ien && (q.p2_flag != 5'h00); // [RL10] [RL17]

		// Read data stand one cycle after the strobe
		if (rd_stb) begin
			case (addr)
				`GPI_OFS_P0_FLAG: begin
					d.rdata = q.p0_flag;
				end
				`GPI_OFS_P1_FLAG: begin
					d.rdata = q.p1_flag;
				end
				`GPI_OFS_P2_FLAG: begin
					d.rdata = {3'h0, q.p2_flag}; // [RL8]
				end
				`GPI_OFS_CTL: begin
					d.rdata = {1'b0, q.boost, q.p2_ien, q.p0_ienh, q.p0_ienl,
						q.fall_sel};
				end
				`GPI_OFS_P1_IEN: begin
					d.rdata = q.p1_ien;
				end
				`GPI_OFS_P0_MODE: begin
					d.rdata = q.p0_mode;
				end
				`GPI_OFS_P1_MODE: begin
					d.rdata = {q.p1_mode, 2'h0};
				end
				`GPI_OFS_P2_MODE: begin
					d.rdata = {q.pull_dn, q.p2_mode};
				end
				default: begin
					d.rdata = `GPI_RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '0; // [RL3] [RL4] [RL5] [RL10] [RL15]
		end else if (ce) begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign drive_boost = q.boost; // [RL9]
	assign p0_irq = q.irq[0];
	assign p1_irq = q.irq[1];
	assign p2_irq = q.irq[2];

	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence p0_clr_all_s;
		ce && wr_p0f && (wdata == 8'h00) && (set_v[7:0] == 8'h00);
	endsequence

	sequence p0_keep_all_s;
		ce && wr_p0f && (wdata == 8'hFF);
	endsequence

	sequence p2_rise_on_s;
		ce && lnk.rise[16] && !q.fall_sel[2] && q.p2_ien;
	endsequence

	p0_rise_flag_a: assert property ( // [RL6]
		ce && lnk.rise[0] && !q.fall_sel[0] |=> q.p0_flag[0])
		else $error("port 0 rising edge did not set flag");

	p1_fall_flag_a: assert property ( // [RL7]
		ce && lnk.fall[8] && q.fall_sel[1] |=> q.p1_flag[0])
		else $error("port 1 falling edge did not set flag");

	edge_select_a: assert property ( // [RL14]
		ce && lnk.rise[3] && q.fall_sel[0] && !q.p0_flag[3]
		|=> !q.p0_flag[3])
		else $error("rising edge flagged while falling selected");

	p2_read_a: assert property ( // [RL8]
		ce && rd_stb && (addr == `GPI_OFS_P2_FLAG)
		|=> (rdata[7:5] == 3'h0) && (rdata[4:0] == $past(q.p2_flag)))
		else $error("port 2 flag read wrong");

	rd_window_a: assert property (
		ce && !rd_stb |=> rdata == 8'h00)
		else $error("read data outside read window");

	p1_mode_read_a: assert property ( // [RL1]
		ce && rd_stb && (addr == `GPI_OFS_P1_MODE) |=> rdata[1:0] == 2'h0)
		else $error("unused port 1 mode bits not zero");

	flag_clear_a: assert property ( // [RL16]
		p0_clr_all_s |=> q.p0_flag == 8'h00)
		else $error("writing zero did not clear flags");

	flag_keep_a: assert property ( // [RL16]
		p0_keep_all_s |=> q.p0_flag == ($past(q.p0_flag) | $past(set_v[7:0])))
		else $error("writing one changed a flag");

	set_wins_a: assert property ( // [RL16]
		ce && wr_p0f && !wdata[1] && lnk.rise[1] && !q.fall_sel[0]
		|=> q.p0_flag[1])
		else $error("event lost against clear");

	p2_irq_path_a: assert property ( // [RL10]
		p2_rise_on_s ##1 ce |=> p2_irq)
		else $error("enabled port 2 event gave no request");

	p2_masked_a: assert property ( // [RL10]
		ce && !q.p2_ien |=> !p2_irq)
		else $error("port 2 request while disabled");

	p0_upper_a: assert property ( // [RL11]
		ce && q.p0_ienh && !q.p0_ienl && (q.p0_flag[3:0] == 4'h0)
		|=> p0_irq == $past(q.p0_flag[7:4] != 4'h0))
		else $error("port 0 upper request wrong");

	p0_lower_a: assert property ( // [RL12]
		ce && q.p0_ienl && !q.p0_ienh && (q.p0_flag[7:4] == 4'h0)
		|=> p0_irq == $past(q.p0_flag[3:0] != 4'h0))
		else $error("port 0 lower request wrong");

	p1_mask_a: assert property ( // [RL15]
		ce && ((q.p1_flag & q.p1_ien) == 8'h00) |=> !p1_irq)
		else $error("port 1 request from masked flag");

	drive_write_a: assert property ( // [RL9]
		ce && wr_stb && (addr == `GPI_OFS_CTL)
		|=> drive_boost == $past(wdata[`GPI_CTL_BOOST]))
		else $error("drive bit not taken");

	pull_dir_write_a: assert property ( // [RL3]
		ce && wr_stb && (addr == `GPI_OFS_P2_MODE)
		|=> lnk.pull_dn == $past(wdata[7:`GPI_PDN_LSB]))
		else $error("pull direction not taken");

	freeze_a: assert property (
		!ce |=> q == $past(q))
		else $error("state moved while enable low");

endmodule : gpi_top

/* verification/gpi_pin_model.sv */
// External pin model: drives pins or leaves them to the pad pulls.
// Assumes the bench picks which pins are driven and to what level.
`timescale 1ns/1ps

module gpi_pin_model (
	// Clock
	input wire logic sys_clk,
	// Pad pulls
	input wire logic [20:0] pull_up_en,
	input wire logic [20:0] pull_down_en,
	// Bench drive
	input wire logic [20:0] drv_en,
	input wire logic [20:0] drv_val,
	// Pins
	output logic [20:0] pin
);
	logic [20:0] flt_q = 21'h000000;

	always_ff @(posedge sys_clk) begin
		flt_q <= ~flt_q;
	end

	// Released pins without a pull wander every cycle
	always_comb begin
		for (int i = 0; i < 21; i++) begin
			if (drv_en[i]) pin[i] = drv_val[i];
			else if (pull_up_en[i]) pin[i] = 1'b1;
			else if (pull_down_en[i]) pin[i] = 1'b0;
			else pin[i] = flt_q[i];
		end
	end
endmodule : gpi_pin_model

/* verification/testbench.sv */
// Self-checking bench of the pin input block with an external pin model.
// Assumes gpi_top and gpi_pin_model are compiled beforehand.
`timescale 1ns/1ps

module testbench;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [20:0] drv_en = 21'h1FFFFF;
	logic [20:0] drv_val = 21'h000000;
	logic [7:0] rdata;
	logic [20:0] pin, pu, pd;
	logic boost;
	logic [2:0] irq;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;

	gpi_top i_gpi_top (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .p0_pin_in(pin[7:0]), .p1_pin_in(pin[15:8]),
		.p2_pin_in(pin[20:16]), .pull_up_en(pu), .pull_down_en(pd),
		.drive_boost(boost), .p0_irq(irq[0]), .p1_irq(irq[1]),
		.p2_irq(irq[2])
	);
	gpi_pin_model i_gpi_pin_model (
		.sys_clk(sys_clk), .pull_up_en(pu), .pull_down_en(pd),
		.drv_en(drv_en), .drv_val(drv_val), .pin(pin)
	);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_fail = n_fail + 1;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [20:0] exp,
		input logic [20:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	// One idle cycle after each access keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		@(negedge sys_clk);
		chk($sformatf("reg %h", a), {13'h0000, exp}, {13'h0000, rdata});
		@(posedge sys_clk);
	endtask : rc

	task automatic test_reset();
		logic [7:0] regs [9] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
			8'h8F, 8'hF6, 8'hF7, 8'h90};
		foreach (regs[i]) begin
			rc(regs[i], 8'h00);
		end
		@(negedge sys_clk);
		chk("pull up", 21'h1FFCFF, pu);
		chk("pull down", 21'h000000, pd);
		chk("boost irq", 21'h000000, {17'h00000, boost, irq});
		@(posedge sys_clk);
		$display("test reset done");
	endtask : test_reset

	task automatic test_pulls();
		logic [23:0] cfg [3] = '{24'h000000, 24'h0FA4A5, 24'hF05A4A};
		logic [20:0] pull, dn;
		foreach (cfg[i]) begin
			wr(8'h8F, cfg[i][23:16]);
			wr(8'hF6, cfg[i][15:8]);
			wr(8'hF7, cfg[i][7:0]);
			rc(8'h8F, cfg[i][23:16]);
			rc(8'hF6, cfg[i][15:8] & 8'hFC);
			rc(8'hF7, cfg[i][7:0]);
			pull = ~{cfg[i][4:0], cfg[i][15:10], 2'b11, cfg[i][23:16]};
			dn = {{5{cfg[i][7]}}, {8{cfg[i][6]}}, {8{cfg[i][5]}}};
			@(negedge sys_clk);
			chk("pull up", pull & ~dn, pu);
			chk("pull down", pull & dn, pd);
			@(posedge sys_clk);
			drv_en <= 21'h000000;
			idle(2);
			@(negedge sys_clk);
			chk("pulled pins", pull & ~dn, pin & pull);
			@(posedge sys_clk);
			drv_en <= 21'h1FFFFF;
		end
		$display("test pulls done");
	endtask : test_pulls

	task automatic test_ctl();
		wr(8'h8C, 8'hFF);
		rc(8'h8C, 8'h7F);
		@(negedge sys_clk);
		chk("boost", 21'h000001, {20'h00000, boost});
		@(posedge sys_clk);
		wr(8'h8C, 8'h00);
		wr(8'h8D, 8'hA5);
		wr(8'h90, 8'hFF);
		rc(8'h8D, 8'hA5);
		rc(8'h90, 8'h00);
		@(negedge sys_clk);
		chk("boost", 21'h000000, {20'h00000, boost});
		@(posedge sys_clk);
		$display("test control done");
	endtask : test_ctl

	// Selected edge on one pin, opposite edge on its neighbour
	task automatic test_flags(input int p, input int f);
		int kl;
		int b;
		logic fb;
		logic [20:0] v;
		kl = (p == 2) ? 3 + f : 3 + 3 * f;
		b = p * 8 + kl;
		fb = f[0];
		v = {21{fb}};
		v[b - 1] = ~fb;
		drv_val <= v;
		wr(8'h8C, 8'h38 | 8'(f << p));
		wr(8'h8D, 8'hFF);
		idle(8);
		for (int q = 0; q < 3; q++) wr(8'h89 + 8'(q), 8'h00);
		v[b - 1] = fb;
		v[b] = ~fb;
		drv_val <= v;
		idle(8);
		v[b] = fb;
		drv_val <= v;
		idle(8);
		for (int q = 0; q < 3; q++) begin
			rc(8'h89 + 8'(q), q == p ? 8'(1 << kl) : 8'h00);
		end
		@(negedge sys_clk);
		chk("irq", 21'(1 << p), {18'h00000, irq});
		@(posedge sys_clk);
		wr(8'h8C, 8'(f << p));
		wr(8'h8D, 8'h00);
		@(negedge sys_clk);
		chk("irq masked", 21'h000000, {18'h00000, irq});
		@(posedge sys_clk);
		wr(8'h89 + 8'(p), 8'hFF);
		rc(8'h89 + 8'(p), 8'(1 << kl));
		wr(8'h89 + 8'(p), ~8'(1 << kl));
		rc(8'h89 + 8'(p), 8'h00);
		$display("test flags port %0d edge %0d done", p, f);
	endtask : test_flags

	// Rising pulse on port 0 pin 1 meets a clear-all write at one edge
	task automatic test_set_wins();
		logic [20:0] v;
		v = 21'h1FFFFD;
		drv_val <= v;
		wr(8'h8C, 8'h00);
		idle(8);
		wr(8'h89, 8'h00);
		v[1] = 1'b1;
		drv_val <= v;
		idle(4);
		wr(8'h89, 8'h00);
		rc(8'h89, 8'h02);
		wr(8'h89, 8'hFD);
		rc(8'h89, 8'h00);
		$display("test set wins done");
	endtask : test_set_wins

	// A write while the enable is low must not land
	task automatic test_freeze();
		ce <= 1'b0;
		wr(8'h8C, 8'h40);
		ce <= 1'b1;
		rc(8'h8C, 8'h00);
		@(negedge sys_clk);
		chk("boost frozen", 21'h000000, {20'h00000, boost});
		@(posedge sys_clk);
		wr(8'h8C, 8'h40);
		rc(8'h8C, 8'h40);
		$display("test freeze done");
	endtask : test_freeze

	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		test_reset();
		test_pulls();
		test_ctl();
		for (int p = 0; p < 3; p++) begin
			for (int f = 0; f < 2; f++) begin
				test_flags(p, f);
			end
		end
		test_set_wins();
		test_freeze();
		summarize();
	end
endmodule : testbench
